// file: hdl/bus_buffer_defs.svh
// Timing constants for the bus buffer connection control.
// Assumes a single 200 MHz clock; counts are derived from the nominal times.
`ifndef BUS_BUFFER_DEFS_SVH
`define BUS_BUFFER_DEFS_SVH
`define CLK_PERIOD_NS 5
// Stuck-low timeout, least time, rounded up
`define STUCK_TIMEOUT_NS 30000000
`define STUCK_TIMEOUT_CYCLES ((`STUCK_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Wait after the stuck split before clocking starts, least time
`define PRECLOCK_WAIT_NS 40000
`define PRECLOCK_WAIT_CYCLES ((`PRECLOCK_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Recovery clock rate, half period rounded down
`define RECOVERY_RATE_HZ 8500
`define RECOVERY_HALF_CYCLES (1000000000 / (2 * `RECOVERY_RATE_HZ * `CLK_PERIOD_NS))
`define RECOVERY_PULSES 16
// Both lines high this long counts as bus idle
`define BUS_IDLE_NS 1300
`define BUS_IDLE_CYCLES ((`BUS_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: hdl/bus_buffer_pkg.sv
// Types shared by the bus buffer connection control.
// Assumes nothing beyond a SystemVerilog compiler.
package bus_buffer_pkg;
  // One sampled two-wire segment
  typedef struct packed {
    logic data;
    logic clock;
  } line_sample_type;
  // Connection state machine
  typedef enum logic [2:0] {
    wait_join,
    joined,
    stuck_wait,
    recover_clock,
    recover_stop,
    stuck_hold
  } state_type;
endpackage

// file: hdl/segment_monitor.sv
// Watches one synchronised two-wire segment for idle and stop conditions.
// Assumes its inputs are already synchronised to clk.
`timescale 1ns/1ps
module segment_monitor #(
  parameter int IDLE_CYCLES = 260
) (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, high
  input wire bus_buffer_pkg::line_sample_type lines, // Synchronised lines
  output logic idle, // Both lines high long enough
  output logic stop // One-cycle pulse on a stop condition
);
  localparam int IW = $clog2(IDLE_CYCLES + 1);
  logic [IW-1:0] idle_cnt_q;
  logic data_prev_q;
  logic stop_q;

  ////////////////////////////////////////////////////////////////////////////
  // Idle counter saturates so idle stays a level
  always_ff @(posedge clk) begin
    if (reset || !lines.data || !lines.clock) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != IW'(IDLE_CYCLES)) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  // Stop is data rising while clock stays high
  always_ff @(posedge clk) begin
    if (reset) begin
      data_prev_q <= 1'b1;
      stop_q <= 1'b0;
    end else begin
      data_prev_q <= lines.data;
      stop_q <= lines.clock && lines.data && !data_prev_q;
    end
  end

  assign idle = (idle_cnt_q == IW'(IDLE_CYCLES));
  assign stop = stop_q;
endmodule

// file: hdl/bus_buffer_connect_control.sv
// Connection control for a live-insertion two-wire bus buffer.
// Assumes the bus, enable and lockout pins are asynchronous to clk and pass through two flip-flops here;
// the analog pass gates and accelerators are steered by the outputs.
// Function
// RULE1 - Enable low: split segments, hold ready low
// RULE2 - Enable high: join only after transactions finish
// RULE3 - Ready released when segments join
// RULE4 - No recovery clocking while enable low
// RULE5 - Enable rise after fault forces join
// RULE6 - Forced join restarts stuck timers, still active
// RULE7 - Joined: accelerators on all four lines
// RULE8 - Accelerators off before join, during recovery
// RULE9 - Controller holds enable low during insertion
// RULE10 - Join on both idle, or stop plus idle
// RULE11 - Card line low too long splits
// RULE12 - Wait, clock up to sixteen, then stop
// RULE13 - Stuck line high: rearm, await stop/idle
// RULE14 - Timeouts counted from clk by parameters
`include "bus_buffer_defs.svh"
`timescale 1ns/1ps
module bus_buffer_connect_control #(
  parameter int STUCK_CYCLES = `STUCK_TIMEOUT_CYCLES,
  parameter int PRECLOCK_CYCLES = `PRECLOCK_WAIT_CYCLES,
  parameter int HALF_CYCLES = `RECOVERY_HALF_CYCLES,
  parameter int PULSES = `RECOVERY_PULSES,
  parameter int IDLE_CYCLES = `BUS_IDLE_CYCLES
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic reset, // Synchronous reset, high
  input wire logic undervoltage_lockout, // Supply too low, high
  input wire logic enable, // Connection enable pin
  input wire logic backplane_data_line_in, // Backplane data level
  input wire logic backplane_clock_line_in, // Backplane clock level
  input wire logic card_data_line_in, // Card data level
  input wire logic card_clock_line_in, // Card clock level
  output logic card_data_line_out, // Card data drive value, always low
  output logic card_data_line_oe, // Card data pulled low
  output logic card_clock_line_out, // Card clock drive value, always low
  output logic card_clock_line_oe, // Card clock pulled low
  output logic ready_out, // Ready drive value, always low
  output logic ready_oe, // Ready pulled low
  output logic connect, // Segments joined
  output logic [3:0] accel_enable // Accelerators: card clk, card data, bp clk, bp data
);
  localparam int SW = $clog2(STUCK_CYCLES + 1);
  localparam int PW = $clog2(PRECLOCK_CYCLES + HALF_CYCLES + 1);
  localparam int CW = $clog2(PULSES + 1);

  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic en_s;
  logic lockout_s;
  logic en_prev_q;
  logic en_rise;
  bus_buffer_pkg::line_sample_type bp_s;
  bus_buffer_pkg::line_sample_type card_s;
  logic bp_idle;
  logic bp_stop;
  logic card_idle;
  logic card_stop;
  logic join_ok;
  logic [SW-1:0] stuck_cnt_q [2];
  logic timeout;
  logic fault_q;
  bus_buffer_pkg::state_type state_q;
  logic [PW-1:0] phase_cnt_q;
  logic [PW-1:0] phase_limit;
  logic tick;
  logic clk_low_q;
  logic [CW-1:0] pulse_cnt_q;
  logic [1:0] stop_phase_q;
  logic hold_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 6'h3c;
      sync2_q <= 6'h3c;
    end else begin
      sync1_q <= {backplane_data_line_in, backplane_clock_line_in, card_data_line_in,
                  card_clock_line_in, undervoltage_lockout, enable};
      sync2_q <= sync1_q;
    end
  end

  assign en_s = sync2_q[0];
  assign lockout_s = sync2_q[1];
  assign card_s = bus_buffer_pkg::line_sample_type'(sync2_q[3:2]);
  assign bp_s = bus_buffer_pkg::line_sample_type'(sync2_q[5:4]);
  // Lockout behaves like reset so nothing acts on a half-powered bus
  assign hold_reset = reset || lockout_s;

  // Enable edge finder; it tracks the pin through lockout so that leaving
  // lockout with enable already high is not taken for a rising edge
  always_ff @(posedge clk) begin
    if (reset) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_s;
    end
  end
  assign en_rise = en_s && !en_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Idle and stop watchers on both segments
  segment_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) bp_monitor (
    .clk(clk),
    .reset(hold_reset),
    .lines(bp_s),
    .idle(bp_idle),
    .stop(bp_stop)
  );
  segment_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) card_monitor (
    .clk(clk),
    .reset(hold_reset),
    .lines(card_s),
    .idle(card_idle),
    .stop(card_stop)
  );
  // Both idle, or a stop on one side with the other idle
  assign join_ok = (bp_idle && card_idle) || (bp_stop && card_idle) ||
                   (bp_idle && card_stop); // RULE10

  ////////////////////////////////////////////////////////////////////////////
  // Stuck-low timers, one per card line; that line going high, reset, lockout or a forced join clears it
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (hold_reset || sync2_q[2+i] || (en_rise && fault_q)) begin // RULE11 RULE6
        stuck_cnt_q[i] <= '0;
      end else if (stuck_cnt_q[i] != SW'(STUCK_CYCLES)) begin
        stuck_cnt_q[i] <= stuck_cnt_q[i] + 1'b1; // RULE14
      end
    end
  end
  assign timeout = (stuck_cnt_q[0] == SW'(STUCK_CYCLES)) ||
                   (stuck_cnt_q[1] == SW'(STUCK_CYCLES));

  ////////////////////////////////////////////////////////////////////////////
  // Recovery timebase: preclock wait, then half periods of the slow clock
  always_comb begin
    if (state_q == bus_buffer_pkg::stuck_wait) begin
      phase_limit = PW'(PRECLOCK_CYCLES); // RULE14
    end else begin
      phase_limit = PW'(HALF_CYCLES);
    end
  end
  assign tick = (phase_cnt_q == phase_limit);

  always_ff @(posedge clk) begin
    if (hold_reset || tick || state_q == bus_buffer_pkg::joined ||
        state_q == bus_buffer_pkg::wait_join || state_q == bus_buffer_pkg::stuck_hold) begin
      phase_cnt_q <= '0;
    end else begin
      phase_cnt_q <= phase_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault memory: a timeout arms the forced join; any join disarms it
  always_ff @(posedge clk) begin
    if (hold_reset) begin
      fault_q <= 1'b0;
    end else if (timeout && en_s && (state_q == bus_buffer_pkg::joined ||
                                     state_q == bus_buffer_pkg::wait_join)) begin
      fault_q <= 1'b1; // Set wins over the clear below
    end else if (state_q == bus_buffer_pkg::joined) begin
      fault_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Connection state machine
  always_ff @(posedge clk) begin
    if (hold_reset) begin
      state_q <= bus_buffer_pkg::wait_join;
    end else if (!en_s) begin
      state_q <= bus_buffer_pkg::wait_join; // RULE1 RULE4
    end else if (en_rise && fault_q) begin
      state_q <= bus_buffer_pkg::joined; // RULE5
    end else begin
      case (state_q)
        bus_buffer_pkg::wait_join: begin
          if (timeout) begin
            state_q <= bus_buffer_pkg::stuck_wait;
          end else if (join_ok) begin
            state_q <= bus_buffer_pkg::joined; // RULE2
          end
        end
        bus_buffer_pkg::joined: begin
          if (timeout) begin
            state_q <= bus_buffer_pkg::stuck_wait; // RULE11
          end
        end
        bus_buffer_pkg::stuck_wait: begin
          if (tick) begin
            state_q <= bus_buffer_pkg::recover_clock; // RULE12
          end
        end
        bus_buffer_pkg::recover_clock: begin
          // Stop early once the card data line is free
          if (tick && !clk_low_q && (pulse_cnt_q == CW'(PULSES) || card_s.data)) begin
            state_q <= bus_buffer_pkg::recover_stop; // RULE12
          end
        end
        bus_buffer_pkg::recover_stop: begin
          if (tick && stop_phase_q == 2'h2) begin
            state_q <= bus_buffer_pkg::stuck_hold;
          end
        end
        bus_buffer_pkg::stuck_hold: begin
          if (card_s.data && card_s.clock) begin
            state_q <= bus_buffer_pkg::wait_join; // RULE13
          end
        end
        default: begin
          state_q <= bus_buffer_pkg::wait_join;
        end
      endcase
    end
  end

  // Recovery clock phase and pulse count
  always_ff @(posedge clk) begin
    if (hold_reset || state_q != bus_buffer_pkg::recover_clock) begin
      clk_low_q <= 1'b1;
      pulse_cnt_q <= '0;
    end else if (tick) begin
      clk_low_q <= !clk_low_q;
      if (clk_low_q) begin
        pulse_cnt_q <= pulse_cnt_q + 1'b1;
      end
    end
  end

  // Stop steps: both low, clock released, then data released
  always_ff @(posedge clk) begin
    if (hold_reset || state_q != bus_buffer_pkg::recover_stop) begin
      stop_phase_q <= 2'h0;
    end else if (tick && stop_phase_q != 2'h2) begin
      stop_phase_q <= stop_phase_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; open-drain so only the enables carry information
  assign card_clock_line_oe = en_s && ((state_q == bus_buffer_pkg::recover_clock && clk_low_q) ||
                              (state_q == bus_buffer_pkg::recover_stop &&
                               stop_phase_q == 2'h0)); // RULE4 RULE12
  assign card_data_line_oe = en_s && state_q == bus_buffer_pkg::recover_stop &&
                             stop_phase_q != 2'h2; // RULE12
  assign card_clock_line_out = 1'b0;
  assign card_data_line_out = 1'b0;
  assign ready_out = 1'b0;
  assign connect = (state_q == bus_buffer_pkg::joined); // RULE1
  assign ready_oe = !(connect && en_s); // RULE1 RULE3
  assign accel_enable = {4{connect}}; // RULE7 RULE8

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_side_done;
    join_ok;
  endsequence
  sequence s_forced;
    en_rise && fault_q && !lockout_s;
  endsequence

  property p_disabled_split;
    @(posedge clk) disable iff (reset) !en_s |=> !connect && ready_oe;
  endproperty
  a_disabled_split: assert property (p_disabled_split) else $error("joined while disabled"); // RULE1

  property p_join_after_done;
    @(posedge clk) disable iff (reset)
      $rose(connect) |-> $past(join_ok) || $past(en_rise && fault_q);
  endproperty
  a_join_after_done: assert property (p_join_after_done) else $error("join mid-transfer"); // RULE2

  property p_ready_on_join;
    @(posedge clk) disable iff (reset) connect && en_s |-> !ready_oe;
  endproperty
  a_ready_on_join: assert property (p_ready_on_join) else $error("ready held low"); // RULE3

  property p_no_clock_disabled;
    @(posedge clk) disable iff (reset) !en_s |-> !card_clock_line_oe && !card_data_line_oe;
  endproperty
  a_no_clock_disabled: assert property (p_no_clock_disabled) else $error("clocking"); // RULE4

  property p_forced_join;
    @(posedge clk) disable iff (reset) s_forced |=> connect [*2];
  endproperty
  a_forced_join: assert property (p_forced_join) else $error("no forced join"); // RULE5

  property p_timer_restart;
    @(posedge clk) disable iff (reset)
      s_forced |=> (stuck_cnt_q[0] == '0 && stuck_cnt_q[1] == '0) ##1
      ($past(card_s.data) || stuck_cnt_q[1] == SW'(1));
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted"); // RULE6

  property p_accel_joined;
    @(posedge clk) disable iff (reset) connect |-> accel_enable == 4'hf;
  endproperty
  a_accel_joined: assert property (p_accel_joined) else $error("accelerators off"); // RULE7

  property p_accel_recovery;
    @(posedge clk) disable iff (reset)
      (card_clock_line_oe || state_q != bus_buffer_pkg::joined) |-> accel_enable == 4'h0;
  endproperty
  a_accel_recovery: assert property (p_accel_recovery) else $error("accelerators on"); // RULE8

  property p_join_condition;
    @(posedge clk) disable iff (reset)
      (state_q == bus_buffer_pkg::wait_join && en_s && !timeout && !en_rise && !lockout_s)
      and s_side_done |=> connect;
  endproperty
  a_join_condition: assert property (p_join_condition) else $error("missed join"); // RULE10

  property p_stuck_split;
    @(posedge clk) disable iff (reset)
      connect && timeout && en_s && !en_rise |=> !connect ##1 !connect;
  endproperty
  a_stuck_split: assert property (p_stuck_split) else $error("no stuck split"); // RULE11

  property p_pulse_bound;
    @(posedge clk) disable iff (reset) pulse_cnt_q <= CW'(PULSES);
  endproperty
  a_pulse_bound: assert property (p_pulse_bound) else $error("too many pulses"); // RULE12

  property p_rearm;
    @(posedge clk) disable iff (reset)
      state_q == bus_buffer_pkg::stuck_hold && en_s && !en_rise && card_s.data && card_s.clock
      |=> state_q == bus_buffer_pkg::wait_join;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no rearm"); // RULE13

  property p_wait_length;
    @(posedge clk) disable iff (reset)
      state_q == bus_buffer_pkg::stuck_wait && tick |-> phase_cnt_q == PW'(PRECLOCK_CYCLES);
  endproperty
  a_wait_length: assert property (p_wait_length) else $error("bad wait"); // RULE14
endmodule

// file: testbench/bus_segment_model.sv
// Far-side devices on the backplane and card segments of the buffer.
// Assumes open-drain lines with pull-ups; the buffer's pull-downs arrive as enables.
`timescale 1ns/1ps
module bus_segment_model (
  input wire logic card_data_oe, // Buffer pulls card data low
  input wire logic card_clock_oe, // Buffer pulls card clock low
  output logic backplane_data_line, // Backplane data level
  output logic backplane_clock_line, // Backplane clock level
  output logic card_data_line, // Card data level
  output logic card_clock_line // Card clock level
);
  logic bp_data_q = 1'b1;
  logic bp_clock_q = 1'b1;
  logic card_hold_q = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Wired-AND with pull-ups: a released line goes high, never keeps a stale low
  assign backplane_data_line = bp_data_q;
  assign backplane_clock_line = bp_clock_q;
  assign card_data_line = !(card_data_oe || card_hold_q);
  assign card_clock_line = !card_clock_oe;
  ////////////////////////////////////////////////////////////////////////////////
  // A card device that jams data low, or lets it go
  task automatic set_stuck(input logic v);
    card_hold_q = v;
  endtask
  // Backplane master: start, bits at the 48 ns link rate, stop; clock idles high
  task automatic bp_frame(input int bits);
    bp_data_q = 1'b0;
    #24 bp_clock_q = 1'b0;
    for (int i = 0; i < bits; i++) begin
      bp_data_q = i[0];
      #24 bp_clock_q = 1'b1;
      #24 bp_clock_q = 1'b0;
    end
    bp_data_q = 1'b0;
    #24 bp_clock_q = 1'b1;
    #24 bp_data_q = 1'b1;
  endtask
endmodule

// file: testbench/bus_buffer_connect_control_tb_top.sv
// Self-checking bench for the buffer connection control.
// Assumes the segment model above; long counts are shortened by parameters.
`timescale 1ns/1ps
module bus_buffer_connect_control_tb_top;
  localparam int STUCK = 200;
  localparam int PRE = 20;
  localparam int HALF = 10;
  localparam int IDLE = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic lockout = 1'b0;
  logic enable = 1'b0;
  logic bp_data, bp_clock, card_data, card_clock, cd_oe, cc_oe, ready_oe, connect;
  logic [3:0] accel;
  logic in_frame = 1'b0;
  int early_join = 0;
  int bad_count = 0;
  int tests_run = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    forever #2.5 clk = !clk;
  end
  bus_segment_model model (.card_data_oe(cd_oe), .card_clock_oe(cc_oe),
    .backplane_data_line(bp_data), .backplane_clock_line(bp_clock),
    .card_data_line(card_data), .card_clock_line(card_clock));
  bus_buffer_connect_control #(.STUCK_CYCLES(STUCK), .PRECLOCK_CYCLES(PRE),
    .HALF_CYCLES(HALF), .PULSES(16), .IDLE_CYCLES(IDLE)) dut (.clk(clk), .reset(reset),
    .undervoltage_lockout(lockout), .enable(enable), .backplane_data_line_in(bp_data),
    .backplane_clock_line_in(bp_clock), .card_data_line_in(card_data),
    .card_clock_line_in(card_clock), .card_data_line_out(), .card_data_line_oe(cd_oe),
    .card_clock_line_out(), .card_clock_line_oe(cc_oe), .ready_out(),
    .ready_oe(ready_oe), .connect(connect), .accel_enable(accel));
  // A join while the backplane frame is still running is a fault
  always @(posedge clk) begin
    if (in_frame && connect === 1'b1) early_join++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      bad_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for connect to reach v; n is the cycle count spent
  task automatic wait_conn(input logic v, input int lim, output int n);
    n = 0;
    while (connect !== v && n < lim) begin
      cycles(1);
      n++;
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Enable low with a jammed card line: no join, no clocking, no accelerators
  task automatic test_enable_low();
    int bad_c, bad_j, bad_a;
    bad_c = 0;
    bad_j = 0;
    bad_a = 0;
    model.set_stuck(1'b1);
    repeat (3 * STUCK) begin
      cycles(1);
      if (cc_oe !== 1'b0) bad_c++;
      if (connect !== 1'b0 || ready_oe !== 1'b1) bad_j++;
      if (accel !== 4'h0) bad_a++;
    end
    chk(bad_c == 0, "recovery clock with enable low");
    chk(bad_j == 0, "joined or ready with enable low");
    chk(bad_a == 0, "accelerators on before join");
    model.set_stuck(1'b0);
    $display("test enable_low done");
  endtask
  // Enable rises mid-frame: join only after the stop
  task automatic test_join();
    int n;
    in_frame = 1'b1;
    fork
      model.bp_frame(18);
      begin
        repeat (10) @(posedge clk);
        enable <= 1'b1;
      end
    join
    in_frame = 1'b0;
    wait_conn(1'b1, 20, n);
    chk(early_join == 0, "joined during a transfer");
    chk(connect === 1'b1, "no join after stop");
    chk(ready_oe === 1'b0, "ready not released");
    chk(accel === 4'hf, "accelerators not all on");
    $display("test join done");
  endtask
  // Card data jams: split after the timeout, sixteen pulses, then a stop
  task automatic test_stuck();
    int n, pulses, first, second, bad_a;
    bit stop_seen;
    logic p_cc, p_cd;
    pulses = 0;
    first = -1;
    second = -1;
    bad_a = 0;
    stop_seen = 0;
    p_cc = 1'b0;
    p_cd = 1'b0;
    model.set_stuck(1'b1);
    wait_conn(1'b0, STUCK + 30, n);
    chk(n >= STUCK && n <= STUCK + 10, "stuck split time");
    chk(ready_oe === 1'b1, "ready high after split");
    for (int i = 0; i < 500; i++) begin
      cycles(1);
      if (cc_oe === 1'b1 && p_cc === 1'b0 && cd_oe === 1'b0) begin
        pulses++;
        if (first < 0) first = i;
        else if (second < 0) second = i;
      end
      if (cd_oe === 1'b0 && p_cd === 1'b1 && cc_oe === 1'b0) stop_seen = 1;
      if (accel !== 4'h0) bad_a++;
      p_cc = cc_oe;
      p_cd = cd_oe;
    end
    chk(first >= PRE, "clocking before the wait");
    chk(second - first == 2 * (HALF + 1), "recovery clock period");
    chk(pulses == 16, "recovery pulse count");
    chk(stop_seen, "no stop after recovery");
    chk(bad_a == 0, "accelerators during recovery");
    $display("test stuck done");
  endtask
  // Enable edge after the fault forces a join; the timer restarts and still works
  task automatic test_forced();
    int n;
    @(posedge clk);
    enable <= 1'b0;
    cycles(10);
    chk(connect === 1'b0 && ready_oe === 1'b1, "split with enable low");
    @(posedge clk);
    enable <= 1'b1;
    wait_conn(1'b1, 10, n);
    chk(connect === 1'b1, "no forced join");
    wait_conn(1'b0, STUCK + 30, n);
    chk(n >= STUCK - 10, "timer not restarted");
    chk(connect === 1'b0, "timeout disabled by forced join");
    $display("test forced done");
  endtask
  // Jam clears: stop the recovery, re-arm, join after idle
  task automatic test_rearm();
    int n;
    model.set_stuck(1'b0);
    wait_conn(1'b1, 300, n);
    chk(connect === 1'b1, "no rejoin after release");
    chk(n > IDLE, "rejoined without idle");
    $display("test rearm done");
  endtask
  // Supply lockout acts as reset: split at once, rejoin only after idle
  task automatic test_lockout();
    int n;
    @(posedge clk);
    lockout <= 1'b1;
    cycles(5);
    chk(connect === 1'b0 && ready_oe === 1'b1 && accel === 4'h0, "joined in lockout");
    @(posedge clk);
    lockout <= 1'b0;
    wait_conn(1'b1, 50, n);
    chk(connect === 1'b1, "no join after lockout");
    chk(n > IDLE, "joined before idle after lockout");
    $display("test lockout done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the expected 1900 cycles
  initial begin
    #100us;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    cycles(5);
    test_enable_low();
    test_join();
    test_stuck();
    test_forced();
    test_rearm();
    test_lockout();
    end_sim();
  end
endmodule
